// File: pds_ctl.sv
// Controller end: serialises one divider word and pulses the latch strobe.
// Assumes a single 25 MHz clock; sclk is derived here by a divider.
`timescale 1ns/1ps
module pds_ctl
    import pds_pkg::*;
#(
    parameter int HALF_CYC = T_MIN_CYC                // Cycles per link interval
) (
    input  wire logic                  CLK,           // System clock
    input  wire logic                  RST_N,         // Async reset, active low
    pds_link_if.ctl                    LINK,          // Serial link to device
    input  wire logic                  START,         // Request pulse
    input  wire logic                  SEL_REF,       // 1 reference word, 0 main word
    input  wire logic [RATIO_BITS-1:0] WORD,          // {main, swallow} or reference
    output logic                       BUSY,          // Transfer in progress
    output logic                       REJECT         // Pulse: word refused
);

    generate
        if (HALF_CYC < T_MIN_CYC) begin : g_bad_half
            $error("HALF_CYC below the 1 us minimum");
        end
    endgenerate

    typedef enum logic [2:0] {
        C_IDLE, C_SETUP, C_HIGH, C_LOW, C_LEWAIT, C_STROBE, C_GAP
    } pds_cstate_t;

    pds_cstate_t                 state_reg;      // Sequencer state
    logic [15:0]                 tick_reg;       // Interval counter
    logic [MAIN_WORD_LEN-1:0]    word_reg;       // Left-aligned word, MSB first
    logic [4:0]                  left_reg;       // Bits still to send
    logic                        sclk_reg;       // Driven link clock
    logic                        sdata_reg;      // Driven data bit
    logic                        strobe_reg;     // Driven latch strobe
    logic                        reject_reg;     // Refusal pulse
    logic                        tick_done;      // Interval elapsed
    logic                        bad_word;       // Word outside its valid range

    assign tick_done = (tick_reg == 16'(HALF_CYC - 1));

    // Range check: main above swallow, main and reference counts not below five
    always_comb begin
        if (SEL_REF) begin
            bad_word = (WORD[REF_LSB +: REF_BITS] < REF_MIN);
        end else begin
            bad_word = (WORD[MAIN_LSB +: MAIN_BITS] < MAIN_MIN) ||
                       (WORD[MAIN_LSB +: MAIN_BITS] <=
                        MAIN_BITS'(WORD[SWALLOW_LSB +: SWALLOW_BITS]));
        end
    end

    // Interval counter restarts on each state change
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            tick_reg <= 16'h0000;
        end else if (state_reg == C_IDLE || tick_done) begin
            tick_reg <= 16'h0000;
        end else begin
            tick_reg <= tick_reg + 16'h0001;
        end
    end

    // Sequencer: data setup, sclk high, sclk low per bit, then the strobe
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_reg  <= C_IDLE;
            word_reg   <= '0;
            left_reg   <= 5'h00;
            sclk_reg   <= 1'b0;
            sdata_reg  <= 1'b0;
            strobe_reg <= 1'b0;
            reject_reg <= 1'b0;
        end else begin
            reject_reg <= 1'b0;
            case (state_reg)
                C_IDLE: begin
                    if (START && bad_word) begin
                        reject_reg <= 1'b1;
                    end else if (START && SEL_REF) begin
                        word_reg  <= {WORD[REF_LSB +: REF_BITS], STEER_REF, 6'h00};
                        sdata_reg <= WORD[REF_LSB + REF_BITS - 1];
                        left_reg  <= 5'(REF_WORD_LEN);
                        state_reg <= C_SETUP;
                    end else if (START) begin
                        word_reg  <= {WORD, STEER_MAIN};
                        sdata_reg <= WORD[RATIO_BITS-1];
                        left_reg  <= 5'(MAIN_WORD_LEN);
                        state_reg <= C_SETUP;
                    end
                end
                C_SETUP: begin
                    // Data set on entry, a full interval ahead of sclk
                    if (tick_done) begin
                        sclk_reg  <= 1'b1;
                        state_reg <= C_HIGH;
                    end
                end
                C_HIGH: begin
                    if (tick_done) begin
                        sclk_reg  <= 1'b0;
                        word_reg  <= {word_reg[MAIN_WORD_LEN-2:0], 1'b0};
                        left_reg  <= left_reg - 5'h01;
                        state_reg <= C_LOW;
                    end
                end
                C_LOW: begin
                    // Hold time before the data may change
                    if (tick_done) begin
                        sdata_reg <= word_reg[MAIN_WORD_LEN-1];
                        state_reg <= (left_reg == 5'h00) ? C_LEWAIT : C_SETUP;
                    end
                end
                C_LEWAIT: begin
                    if (tick_done) begin
                        strobe_reg <= 1'b1;
                        state_reg  <= C_STROBE;
                    end
                end
                C_STROBE: begin
                    if (tick_done) begin
                        strobe_reg <= 1'b0;
                        state_reg  <= C_GAP;
                    end
                end
                C_GAP: begin
                    // Keeps the strobe a distinct pulse before the next word
                    if (tick_done) begin
                        state_reg <= C_IDLE;
                    end
                end
                default: begin
                    state_reg <= C_IDLE;
                end
            endcase
        end
    end

    assign LINK.sclk         = sclk_reg;
    assign LINK.sdata        = sdata_reg;
    assign LINK.latch_strobe = strobe_reg;
    assign BUSY              = (state_reg != C_IDLE);
    assign REJECT            = reject_reg;

endmodule // pds_ctl

// File: pds_dev.sv
// Divider device end: serial loader, ratio latches and monitor dividers.
// Assumes the link clock stops between words; the divider side runs on CLK.
// Ratios read zero after reset.
// The strobe qualifies every crossing word.
//
// Notes on behaviour
// - Reference word: 12 ratio bits, steering bit
// - Main word: 7 swallow, 11 main, steering
// - Steering 0 selects main, 1 selects reference
// - Data shifts in on the serial clock
// - Latch loads when strobe AND steering select
// - Swallow count plain binary, 0 to 127
// - Main count plain binary, 5 to 2047
// - Reference count plain binary, 5 to 4095
// - Power and test high enable monitor outputs
// - Monitor outputs low outside monitor mode
// - Over-long words keep the last bits
// - Controller loads both dividers after power-up
// - Loading one divider keeps the other
// - Main count must exceed swallow count
// - Power select high active, low standby
`timescale 1ns/1ps
module pds_dev
    import pds_pkg::*;
#(
    parameter int MODULUS = PRESCALE_M                // Prescaler modulus M
) (
    input  wire logic                    CLK,               // Divider clock
    input  wire logic                    RST_N,             // Async reset, active low
    pds_link_if.dev                      LINK,              // Serial link input
    input  wire logic                    POWER_SAVE_SELECT, // High active, low standby
    input  wire logic                    TEST_SELECT,       // Test pin
    output logic                         REF_MONITOR_OUT,   // Reference divider monitor
    output logic                         DIV_MONITOR_OUT,   // Main divider monitor
    output logic [REF_BITS-1:0]          REFERENCE_COUNT_BITS, // Latched reference ratio
    output logic [SWALLOW_BITS-1:0]      SWALLOW_COUNT_BITS,   // Latched swallow ratio
    output logic [MAIN_BITS-1:0]         MAIN_COUNT_BITS       // Latched main ratio
);

    // Total main ratio M*N+A must fit the divider counter
    localparam int TOTAL_BITS = RATIO_BITS;

    // Only a power of two lets a shift stand for the multiply
    generate
        if (MODULUS != (1 << SWALLOW_BITS)) begin : g_bad_mod
            $error("MODULUS must equal two to the swallow width");
        end
    endgenerate

    // Link clock domain
    // Written on rising sclk only

    logic [RATIO_BITS-1:0]       shift_reg;        // Ratio shift register
    logic                        steer_reg;        // Steering bit register

    // Each rising sclk pushes the previous last bit into the ratio
    // register, so bits beyond the word length simply fall off the top.
    // The async reset is released while sclk is idle, so no sync is needed.
    // Zero reset stands in for undefined contents
    always_ff @(posedge LINK.sclk or negedge RST_N) begin
        if (!RST_N) begin
            shift_reg <= SHIFT_RESET;
            steer_reg <= STEER_MAIN;
        end else begin
            shift_reg <= {shift_reg[RATIO_BITS-2:0], steer_reg};
            steer_reg <= LINK.sdata;
        end
    end

    // System clock domain
    // Latches, dividers and monitor pins

    // Two stages per pin
    logic                        strobe_meta;      // Strobe sync, first stage
    logic                        strobe_sync;      // Strobe sync, second stage
    logic                        ps_meta;          // Power select, first stage
    logic                        ps_sync;          // Power select, second stage
    logic                        test_meta;        // Test pin, first stage
    logic                        test_sync;        // Test pin, second stage

    // Pin synchronisers; only the second stage feeds logic
    // Reset low: no false strobe at wake-up
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            strobe_meta <= 1'b0;
            strobe_sync <= 1'b0;
            ps_meta     <= 1'b0;
            ps_sync     <= 1'b0;
            test_meta   <= 1'b0;
            test_sync   <= 1'b0;
        end else begin
            strobe_meta <= LINK.latch_strobe;
            strobe_sync <= strobe_meta;
            ps_meta     <= POWER_SAVE_SELECT;
            ps_sync     <= ps_meta;
            test_meta   <= TEST_SELECT;
            test_sync   <= test_meta;
        end
    end

    // Ratio latches and their enables
    logic [REF_BITS-1:0]         ref_reg;          // Reference ratio latch
    logic [SWALLOW_BITS-1:0]     swallow_reg;      // Swallow ratio latch
    logic [MAIN_BITS-1:0]        main_reg;         // Main ratio latch
    logic                        ref_load;         // Reference latch enable
    logic                        main_load;        // Main latch enable

    // Strobe AND steering bit; the shift and steering registers are static
    // while the strobe is high because sclk stops, so the synchronised
    // strobe acts as the request of a crossing for the whole word.
    // Steering picks exactly one latch
    assign ref_load  = strobe_sync &&  (steer_reg == STEER_REF);
    assign main_load = strobe_sync &&  (steer_reg == STEER_MAIN);

    // Reference latch, touched only by reference words
    // Main words leave it alone
    // Ratio in the low shift bits
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ref_reg <= REF_RESET;
        end else if (ref_load) begin
            ref_reg <= shift_reg[REF_LSB +: REF_BITS];
        end
    end

    // Main and swallow latches, touched only by main words
    // Both halves load together
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            swallow_reg <= SWALLOW_RESET;
            main_reg    <= MAIN_RESET;
        end else if (main_load) begin
            swallow_reg <= shift_reg[SWALLOW_LSB +: SWALLOW_BITS];
            main_reg    <= shift_reg[MAIN_LSB +: MAIN_BITS];
        end
    end

    // Divider counters
    // Counters run on CLK in place of the inputs

    // Wraps once the count reaches ratio less one
    function automatic logic wraps(input logic [TOTAL_BITS-1:0] c, r);
        return (c >= r - 18'h00001);
    endfunction

    // Ratios below five are not guarded here
    logic                        active;           // Active mode
    logic                        monitor;          // Monitor mode
    logic [REF_BITS-1:0]         ref_cnt_reg;      // Reference divider count
    logic [TOTAL_BITS-1:0]       div_cnt_reg;      // Main divider count
    logic [TOTAL_BITS-1:0]       div_total;        // M*N+A
    logic                        ref_tick;         // Reference divider wraps
    logic                        div_tick;         // Main divider wraps

    // Modes from the synchronised pins
    assign active    = ps_sync;
    assign monitor   = ps_sync && test_sync;
    // Shift replaces the multiply since M is a power of two
    assign div_total = {main_reg, swallow_reg};
    assign ref_tick  = wraps(TOTAL_BITS'(ref_cnt_reg), TOTAL_BITS'(ref_reg));
    assign div_tick  = wraps(div_cnt_reg, div_total);

    // Standby clears the counters so both restart in phase
    // when the device becomes active again
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ref_cnt_reg <= '0;
        end else if (!active || ref_tick) begin
            ref_cnt_reg <= '0;
        end else begin
            ref_cnt_reg <= ref_cnt_reg + 12'h001;
        end
    end

    // Main divider, same restart on standby
    // One pulse per M*N+A input cycles
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            div_cnt_reg <= '0;
        end else if (!active || div_tick) begin
            div_cnt_reg <= '0;
        end else begin
            div_cnt_reg <= div_cnt_reg + 18'h00001;
        end
    end

    // Monitor pins carry one-cycle divider pulses, else low
    // Registered, so compares never glitch them
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            REF_MONITOR_OUT <= 1'b0;
            DIV_MONITOR_OUT <= 1'b0;
        end else begin
            REF_MONITOR_OUT <= monitor && active && ref_tick;
            DIV_MONITOR_OUT <= monitor && active && div_tick;
        end
    end

    // Latched ratios are visible for observation
    // Straight from the latch flip-flops
    assign REFERENCE_COUNT_BITS = ref_reg;
    assign SWALLOW_COUNT_BITS   = swallow_reg;
    assign MAIN_COUNT_BITS      = main_reg;

endmodule // pds_dev

// File: pds_link_asserts.sv
// Checker for the serial divider link and the signals of both ends.
// Assumes the link clock is made from CLK, so CLK sampling sees every edge.
`timescale 1ns/1ps
module pds_link_asserts
    import pds_pkg::*;
(
    input wire logic                    CLK,                  // System clock
    input wire logic                    RST_N,                // Async reset, active low
    input wire logic                    sclk,                 // Link clock
    input wire logic                    sdata,                // Link data
    input wire logic                    latch_strobe,         // Link strobe
    input wire logic                    BUSY,                 // Controller busy
    input wire logic                    REJECT,               // Controller refusal
    input wire logic                    POWER_SAVE_SELECT,    // High active
    input wire logic                    TEST_SELECT,          // Test pin
    input wire logic                    REF_MONITOR_OUT,      // Reference monitor
    input wire logic                    DIV_MONITOR_OUT,      // Main monitor
    input wire logic [REF_BITS-1:0]     REFERENCE_COUNT_BITS, // Reference ratio
    input wire logic [SWALLOW_BITS-1:0] SWALLOW_COUNT_BITS,   // Swallow ratio
    input wire logic [MAIN_BITS-1:0]    MAIN_COUNT_BITS       // Main ratio
);
    logic       sclk_q;    // Link clock one cycle late
    logic       steer_reg; // Last bit shifted, i.e. the steering bit
    logic [3:0] since_reg; // Cycles since strobe high, saturating

    // Follow the steering bit as the device shifts it
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            sclk_q    <= 1'b0;
            steer_reg <= 1'b0;
        end else begin
            sclk_q <= sclk;
            if (sclk && !sclk_q) begin // Rising link clock
                steer_reg <= sdata;
            end
        end
    end

    // Age of the strobe; a load far from any strobe is a stray write
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            since_reg <= 4'hf;
        end else if (latch_strobe) begin
            since_reg <= 4'h0;
        end else if (since_reg != 4'hf) begin
            since_reg <= since_reg + 4'h1;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    sdata_hold_a: assert property (sclk |-> $stable(sdata))
        else $error("Data moved while link clock high");
    sclk_width_a: assert property ($rose(sclk) |-> sclk[*8])
        else $error("Link clock pulse too short");
    strobe_width_a: assert property ($rose(latch_strobe) |-> latch_strobe[*8])
        else $error("Strobe pulse too short");
    strobe_quiet_a: assert property (latch_strobe |-> !sclk)
        else $error("Link clock high during strobe");
    ref_load_a: assert property (!$stable(REFERENCE_COUNT_BITS) |-> since_reg <= 4'h8
        && steer_reg == STEER_REF && $stable({MAIN_COUNT_BITS, SWALLOW_COUNT_BITS}))
        else $error("Reference ratio loaded without its strobe");
    main_load_a: assert property (!$stable({MAIN_COUNT_BITS, SWALLOW_COUNT_BITS}) |->
        since_reg <= 4'h8 && steer_reg == STEER_MAIN && $stable(REFERENCE_COUNT_BITS))
        else $error("Main ratio loaded without its strobe");
    mon_off_a: assert property ((!(POWER_SAVE_SELECT && TEST_SELECT))[*4] |->
        !REF_MONITOR_OUT && !DIV_MONITOR_OUT)
        else $error("Monitor output outside monitor mode");
    ref_gap_a: assert property (REF_MONITOR_OUT |=> !REF_MONITOR_OUT[*4])
        else $error("Reference monitor pulses too close");
    reject_idle_a: assert property (REJECT |-> !BUSY ##1 !BUSY)
        else $error("Refused word started a transfer");
    idle_link_a: assert property (!BUSY |-> !sclk && !latch_strobe)
        else $error("Link active while controller idle");
endmodule // pds_link_asserts

// File: pds_link_if.sv
// Three-wire serial link between controller and divider device.
// Controller drives every wire; the device only listens.
`timescale 1ns/1ps
interface pds_link_if;
    logic sclk;          // Serial shift clock, made by the controller
    logic sdata;         // Serial data, sampled on rising sclk
    logic latch_strobe;  // Latch strobe pulse after a word

    modport dev (
        input sclk,
        input sdata,
        input latch_strobe
    );

    modport ctl (
        output sclk,
        output sdata,
        output latch_strobe
    );
endinterface : pds_link_if

// File: pds_pkg.sv
// Shared constants for the divider serial programming link.
// Assumes a 25 MHz system clock on both ends; the link clock is serial.
package pds_pkg;

    // Word layout
    localparam int REF_BITS       = 12;               // Reference ratio width
    localparam int SWALLOW_BITS   = 7;                // Swallow count width
    localparam int MAIN_BITS      = 11;               // Main count width
    localparam int RATIO_BITS     = SWALLOW_BITS + MAIN_BITS; // 18 ratio bits
    localparam int REF_WORD_LEN   = REF_BITS + 1;     // 13 bits with steering
    localparam int MAIN_WORD_LEN  = RATIO_BITS + 1;   // 19 bits with steering
    localparam int SWALLOW_LSB    = 0;                // Swallow field position
    localparam int MAIN_LSB       = SWALLOW_BITS;     // Main field position
    localparam int REF_LSB        = 0;                // Reference field position

    // Steering bit encodings
    localparam logic STEER_MAIN   = 1'b0;             // Word goes to main divider
    localparam logic STEER_REF    = 1'b1;             // Word goes to reference divider

    // Valid ranges
    localparam logic [MAIN_BITS-1:0] MAIN_MIN  = 11'h005; // Least main count
    localparam logic [REF_BITS-1:0]  REF_MIN   = 12'h005; // Least reference count

    // Reset values of the latched ratios (contents are undefined on the part)
    localparam logic [REF_BITS-1:0]     REF_RESET     = 12'h000;
    localparam logic [SWALLOW_BITS-1:0] SWALLOW_RESET = 7'h00;
    localparam logic [MAIN_BITS-1:0]    MAIN_RESET    = 11'h000;
    localparam logic [RATIO_BITS-1:0]   SHIFT_RESET   = 18'h00000;

    // Prescaler modulus used by pulse-swallow division
    localparam int PRESCALE_M     = 128;

    // Timing: every serial interval is at least 1 us
    localparam int CLK_PERIOD_NS  = 40;               // 25 MHz system clock
    localparam int T_MIN_NS       = 1000;             // Setup, hold, width minimum
    localparam int T_MIN_CYC      = (T_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : pds_pkg

// File: pll_divider_serial_loader_tb_top.sv
// Bench: controller and device joined by one link; a second device on a
// bench-driven link receives over-long words. Assumes 25 MHz CLK.
`timescale 1ns/1ps
`define CHK(a, e, m) begin num_checks++; if ((a) !== (e)) begin miscompares++; $display("CHECK FAILED %0t %s", $time, m); end end
module pll_divider_serial_loader_tb_top;
    import pds_pkg::*;
    logic                    CLK, RST_N, start, sel_ref, busy, reject; // Control
    logic                    ps, test, ref_mon, div_mon; // Mode pins, monitors
    logic [RATIO_BITS-1:0]   word;          // Word to send
    logic [REF_BITS-1:0]     ref_b, ref2;   // Reference ratios
    logic [SWALLOW_BITS-1:0] sw_b, sw2;     // Swallow ratios
    logic [MAIN_BITS-1:0]    main_b, main2; // Main ratios
    logic [31:0]             cap;           // Bits seen on the link
    int                      cap_n, miscompares, num_checks;

    pds_link_if link();  // Controller to device
    pds_link_if link2(); // Bench to second device

    pds_ctl u_pds_ctl (.CLK(CLK), .RST_N(RST_N), .LINK(link), .START(start),
        .SEL_REF(sel_ref), .WORD(word), .BUSY(busy), .REJECT(reject));
    pds_dev u_pds_dev (.CLK(CLK), .RST_N(RST_N), .LINK(link), .POWER_SAVE_SELECT(ps),
        .TEST_SELECT(test), .REF_MONITOR_OUT(ref_mon), .DIV_MONITOR_OUT(div_mon),
        .REFERENCE_COUNT_BITS(ref_b), .SWALLOW_COUNT_BITS(sw_b), .MAIN_COUNT_BITS(main_b));
    pds_dev u_pds_dev_2 (.CLK(CLK), .RST_N(RST_N), .LINK(link2), .POWER_SAVE_SELECT(ps),
        .TEST_SELECT(test), .REF_MONITOR_OUT(), .DIV_MONITOR_OUT(),
        .REFERENCE_COUNT_BITS(ref2), .SWALLOW_COUNT_BITS(sw2), .MAIN_COUNT_BITS(main2));
    pds_link_asserts u_chk (.CLK(CLK), .RST_N(RST_N), .sclk(link.sclk), .sdata(link.sdata),
        .latch_strobe(link.latch_strobe), .BUSY(busy), .REJECT(reject),
        .POWER_SAVE_SELECT(ps), .TEST_SELECT(test), .REF_MONITOR_OUT(ref_mon),
        .DIV_MONITOR_OUT(div_mon), .REFERENCE_COUNT_BITS(ref_b),
        .SWALLOW_COUNT_BITS(sw_b), .MAIN_COUNT_BITS(main_b));

    // 40 ns system clock
    initial begin
        CLK = 1'b0;
        forever #20 CLK = ~CLK;
    end

    // Record bits in link order, first bit ends up highest
    always @(posedge link.sclk) begin
        cap = {cap[30:0], link.sdata};
        cap_n++;
    end

    // One word through the controller; waits out the transfer
    task automatic send(input logic sel, input logic [17:0] w, input logic rej, input int n);
        cap = 32'h0;
        cap_n = 0;
        @(posedge CLK);
        start <= 1'b1;
        sel_ref <= sel;
        word <= w;
        @(posedge CLK);
        start <= 1'b0;
        #1;
        `CHK(reject, rej, "refusal flag")
        for (int i = 0; i < 4000 && busy === 1'b1; i++) begin
            @(posedge CLK);
            #1;
        end
        `CHK(busy, 1'b0, "transfer did not end")
        `CHK(cap_n, n, "bit count on link")
    endtask

    // Boundary reference ratios, largest then smallest
    task automatic t_ref();
        logic [11:0] rv[2] = '{12'hfff, 12'h005};
        foreach (rv[i]) begin
            send(STEER_REF, {6'h00, rv[i]}, 1'b0, REF_WORD_LEN);
            `CHK(cap[12:0], {rv[i], STEER_REF}, "reference word on link")
            `CHK(ref_b, rv[i], "reference ratio")
            `CHK({main_b, sw_b}, 18'h00000, "main ratio disturbed")
        end
    endtask

    // Boundary main and swallow counts
    task automatic t_main();
        logic [17:0] mv[2] = '{{11'h7ff, 7'h7f}, {11'h005, 7'h03}};
        foreach (mv[i]) begin
            send(STEER_MAIN, mv[i], 1'b0, MAIN_WORD_LEN);
            `CHK(cap[18:0], {mv[i], STEER_MAIN}, "main word on link")
            `CHK(main_b, mv[i][17:7], "main count")
            `CHK(sw_b, mv[i][6:0], "swallow count")
            `CHK(ref_b, 12'h005, "reference ratio disturbed")
        end
    endtask

    // Out-of-range words are refused and change nothing
    task automatic t_reject();
        logic [18:0] bad[3] = '{{1'b1, 18'h00004}, {1'b0, 11'h005, 7'h05}, {1'b0, 11'h004, 7'h00}};
        foreach (bad[i]) begin
            send(bad[i][18], bad[i][17:0], 1'b1, 0);
            `CHK({ref_b, main_b, sw_b}, {12'h005, 11'h005, 7'h03}, "refused word")
        end
    endtask

    // Cycles to the first monitor pulse, then to the next
    task automatic gap_of(input logic div, output int f, output int g);
        f = 0;
        g = 0;
        do begin
            @(posedge CLK);
            #1;
            f++;
        end while ((div ? div_mon : ref_mon) !== 1'b1 && f < 5000);
        do begin
            @(posedge CLK);
            #1;
            g++;
        end while ((div ? div_mon : ref_mon) !== 1'b1 && g < 5000);
    endtask

    // Monitors stay low unless both pins are high, then pulse per wrap
    task automatic t_monitor();
        logic [1:0] md[2] = '{2'b10, 2'b01};
        int         f, g, p;
        foreach (md[i]) begin
            @(posedge CLK);
            {ps, test} <= md[i];
            p = 0;
            repeat (60) begin
                @(posedge CLK);
                #1;
                p += int'(ref_mon === 1'b1 || div_mon === 1'b1);
            end
            `CHK(p, 0, "monitor pulse outside monitor mode")
        end
        @(posedge CLK);
        {ps, test} <= 2'b11;
        gap_of(1'b0, f, g);
        // From standby: two sync stages, then one reference period
        `CHK(f, 2 + 5, "restart after standby")
        `CHK(g, 5, "reference monitor period")
        gap_of(1'b1, f, g);
        `CHK(g, PRESCALE_M * 5 + 3, "main monitor period")
        @(posedge CLK);
        {ps, test} <= 2'b00;
    endtask

    // Bench as controller on the second link; sends n bits MSB first
    task automatic drv(input logic [31:0] b, input int n);
        @(posedge CLK);
        for (int i = n - 1; i >= 0; i--) begin
            link2.sdata <= b[i];
            repeat (T_MIN_CYC) @(posedge CLK);
            link2.sclk <= 1'b1;
            repeat (T_MIN_CYC) @(posedge CLK);
            link2.sclk <= 1'b0;
            repeat (T_MIN_CYC) @(posedge CLK);
        end
        link2.latch_strobe <= 1'b1;
        repeat (T_MIN_CYC) @(posedge CLK);
        link2.latch_strobe <= 1'b0;
        link2.sdata <= ~b[0]; // No stale data after the frame
        repeat (T_MIN_CYC) @(posedge CLK);
    endtask

    // Over-long words keep only their last bits
    task automatic t_overlong();
        drv({16'h0, 3'b101, 12'ha5c, STEER_REF}, 16);
        `CHK(ref2, 12'ha5c, "long reference word")
        `CHK({main2, sw2}, 18'h00000, "main ratio disturbed")
        drv({11'h0, 2'b11, 11'h123, 7'h45, STEER_MAIN}, 21);
        `CHK({main2, sw2}, {11'h123, 7'h45}, "long main word")
        `CHK(ref2, 12'ha5c, "reference ratio disturbed")
    endtask

    // Verdict and end of run
    task automatic give_verdict();
        if (miscompares == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Main sequence; power-up in standby, both dividers loaded
    initial begin
        RST_N = 1'b0;
        start = 1'b0;
        sel_ref = 1'b0;
        word = '0;
        ps = 1'b0;
        test = 1'b0;
        link2.sclk = 1'b0;
        link2.sdata = 1'b0;
        link2.latch_strobe = 1'b0;
        repeat (4) @(posedge CLK);
        RST_N <= 1'b1;
        t_ref();
        t_main();
        t_reject();
        t_monitor();
        t_overlong();
        give_verdict();
    end

    // Hang guard, well past the roughly 9400 cycles of the run
    initial begin
        repeat (60000) @(posedge CLK);
        miscompares++;
        give_verdict();
    end
endmodule // pll_divider_serial_loader_tb_top
